// [design/amon_regs.svh]
// Register offsets, field positions, reset values of the activity monitor
`ifndef AMON_REGS_SVH
`define AMON_REGS_SVH

// ---------------------------------------------------------------------
// Address decode
// ---------------------------------------------------------------------
`define AMON_REGION_DEFAULT 5'h08
`define AMON_REGION_MSB 21
`define AMON_REGION_LSB 17
`define AMON_LOCAL_MSB 16

// ---------------------------------------------------------------------
// Local offsets
// ---------------------------------------------------------------------
`define AMON_OFS_REPEAT_START 17'h13800
`define AMON_OFS_SINGLE_START 17'h13804
`define AMON_OFS_INTERVAL 17'h13808
`define AMON_OFS_DONE 17'h1380C
`define AMON_OFS_WR_PC0 17'h13814
`define AMON_OFS_WR_PC1 17'h13818
`define AMON_OFS_WRAP_PC0 17'h13820
`define AMON_OFS_WRAP_PC1 17'h13824
`define AMON_OFS_RD_PC0 17'h1382C
`define AMON_OFS_RD_PC1 17'h13830
`define AMON_OFS_RDAP_PC0 17'h13838
`define AMON_OFS_RDAP_PC1 17'h1383C
`define AMON_OFS_REF_PC0 17'h13844
`define AMON_OFS_REF_PC1 17'h13848
`define AMON_OFS_ACT_PC0 17'h13850
`define AMON_OFS_ACT_PC1 17'h13854
`define AMON_OFS_PRE_PC0 17'h1385C
`define AMON_OFS_PRE_PC1 17'h13860
`define AMON_OFS_PREALL_PC0 17'h13868
`define AMON_OFS_PREALL_PC1 17'h1386C
`define AMON_OFS_POWERDOWN 17'h13870
`define AMON_OFS_SELFREF 17'h13874
`define AMON_OFS_TURN_PC0 17'h1387C
`define AMON_OFS_TURN_PC1 17'h13880
`define AMON_OFS_AGE_PC0 17'h13888
`define AMON_OFS_AGE_PC1 17'h1388C
`define AMON_OFS_RMW_PC0 17'h13894
`define AMON_OFS_RMW_PC1 17'h13898

// ---------------------------------------------------------------------
// Fields, counter layout and reset values
// ---------------------------------------------------------------------
`define AMON_BIT_CTL 0
`define AMON_EVT_PER_PC 11
`define AMON_IDX_PD 22
`define AMON_IDX_SR 23
`define AMON_NUM_CNT 24
`define AMON_IDX_NONE 5'h1F
`define AMON_RST_INTERVAL 32'h0000_0000
`define AMON_RST_COUNT 32'h0000_0000

`endif

// [design/amon_pkg.sv]
// Types shared by the activity monitor
package amon_pkg;

  // Command issued by the controller to one pseudo channel
  typedef enum logic [2:0] {
    CMD_WRITE,
    CMD_WRITE_AP,
    CMD_READ,
    CMD_READ_AP,
    CMD_REFRESH,
    CMD_ACTIVATE,
    CMD_PRE_BANK,
    CMD_PRE_ALL
  } amon_cmd_e;

  // Position of each per-channel counter within its channel group
  typedef enum logic [3:0] {
    EV_WR,
    EV_WRAP,
    EV_RD,
    EV_RDAP,
    EV_REF,
    EV_ACT,
    EV_PRE,
    EV_PREALL,
    EV_TURN,
    EV_AGE,
    EV_RMW
  } amon_evt_e;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } amon_state_e;

endpackage

// [design/amon_monitor.sv]
// Memory controller activity monitor with its register slave
`timescale 1ns/1ps
`include "amon_regs.svh"

// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
module amon_monitor #(
  parameter logic [4:0] REGION = `AMON_REGION_DEFAULT
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [21:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [1:0] cmd_valid_in,
  input wire amon_pkg::amon_cmd_e cmd_pc0_in,
  input wire amon_pkg::amon_cmd_e cmd_pc1_in,
  input wire logic [1:0] age_limit_in,
  input wire logic [1:0] rmw_in,
  input wire logic powerdown_in,
  input wire logic selfrefresh_in,
  output logic busy_out,
  output logic done_out
);

  // -------------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------------
  function automatic logic [4:0] cnt_index(input logic [16:0] ofs);
    case (ofs)
      `AMON_OFS_WR_PC0: cnt_index = 5'h00;
      `AMON_OFS_WRAP_PC0: cnt_index = 5'h01;
      `AMON_OFS_RD_PC0: cnt_index = 5'h02;
      `AMON_OFS_RDAP_PC0: cnt_index = 5'h03;
      `AMON_OFS_REF_PC0: cnt_index = 5'h04;
      `AMON_OFS_ACT_PC0: cnt_index = 5'h05;
      `AMON_OFS_PRE_PC0: cnt_index = 5'h06;
      `AMON_OFS_PREALL_PC0: cnt_index = 5'h07;
      `AMON_OFS_TURN_PC0: cnt_index = 5'h08;
      `AMON_OFS_AGE_PC0: cnt_index = 5'h09;
      `AMON_OFS_RMW_PC0: cnt_index = 5'h0A;
      `AMON_OFS_WR_PC1: cnt_index = 5'h0B;
      `AMON_OFS_WRAP_PC1: cnt_index = 5'h0C;
      `AMON_OFS_RD_PC1: cnt_index = 5'h0D;
      `AMON_OFS_RDAP_PC1: cnt_index = 5'h0E;
      `AMON_OFS_REF_PC1: cnt_index = 5'h0F;
      `AMON_OFS_ACT_PC1: cnt_index = 5'h10;
      `AMON_OFS_PRE_PC1: cnt_index = 5'h11;
      `AMON_OFS_PREALL_PC1: cnt_index = 5'h12;
      `AMON_OFS_TURN_PC1: cnt_index = 5'h13;
      `AMON_OFS_AGE_PC1: cnt_index = 5'h14;
      `AMON_OFS_RMW_PC1: cnt_index = 5'h15;
      `AMON_OFS_POWERDOWN: cnt_index = 5'h16;
      `AMON_OFS_SELFREF: cnt_index = 5'h17;
      default: cnt_index = `AMON_IDX_NONE;
    endcase
  endfunction

  function automatic logic is_write(input amon_pkg::amon_cmd_e c);
    is_write = (c == amon_pkg::CMD_WRITE) || (c == amon_pkg::CMD_WRITE_AP);
  endfunction

  function automatic logic is_read(input amon_pkg::amon_cmd_e c);
    is_read = (c == amon_pkg::CMD_READ) || (c == amon_pkg::CMD_READ_AP);
  endfunction

  // -------------------------------------------------------------------
  // Register bus decode
  // -------------------------------------------------------------------
  logic [16:0] local_ofs;
  logic region_hit;
  logic [4:0] rd_idx;
  logic ctl_hit;
  logic setup;
  logic access;
  logic wr_acc;
  logic rd_done_acc;

  logic repeat_start_ctl;
  logic single_start;
  logic [31:0] interval_length;
  amon_pkg::amon_state_e state;
  logic [31:0] cyc;
  logic [31:0] last_cyc;
  logic interval_end;
  logic start_req;
  logic [1:0] last_rd;
  logic [`AMON_NUM_CNT-1:0] ev;
  logic [31:0] run_cnt [`AMON_NUM_CNT];
  logic [31:0] trk_cnt [`AMON_NUM_CNT];
  logic [31:0] next_rdata;

  // Only the local space of the selected region answers without error
  assign local_ofs = paddr_in[`AMON_LOCAL_MSB:0];
  assign region_hit = paddr_in[`AMON_REGION_MSB:`AMON_REGION_LSB] == REGION;
  assign rd_idx = cnt_index(local_ofs);
  assign ctl_hit = (local_ofs == `AMON_OFS_REPEAT_START)
                || (local_ofs == `AMON_OFS_SINGLE_START)
                || (local_ofs == `AMON_OFS_INTERVAL)
                || (local_ofs == `AMON_OFS_DONE);
  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in && pready_out && !pslverr_out;
  assign wr_acc = access && pwrite_in;
  assign rd_done_acc = access && !pwrite_in
                    && (local_ofs == `AMON_OFS_DONE);

  // Read data is formed in the setup phase and stands for the access
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (local_ofs)
      `AMON_OFS_REPEAT_START: next_rdata[`AMON_BIT_CTL] = repeat_start_ctl;
      `AMON_OFS_SINGLE_START: next_rdata[`AMON_BIT_CTL] = single_start;
      `AMON_OFS_INTERVAL: next_rdata = interval_length;
      `AMON_OFS_DONE: next_rdata[`AMON_BIT_CTL] = done_out;
      default: begin
        if (rd_idx != `AMON_IDX_NONE) begin
          next_rdata = trk_cnt[rd_idx];
        end
      end
    endcase
  end

  // One wait-free access phase: ready is raised right after setup
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= setup;
      pslverr_out <= setup && !(region_hit
                     && (ctl_hit || rd_idx != `AMON_IDX_NONE));
      prdata_out <= (setup && region_hit) ? next_rdata : 32'h0000_0000;
    end
  end

  // -------------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      repeat_start_ctl <= 1'b0;
      single_start <= 1'b0;
      interval_length <= `AMON_RST_INTERVAL;
    end else if (wr_acc) begin
      case (local_ofs)
        `AMON_OFS_REPEAT_START:
          repeat_start_ctl <= pwdata_in[`AMON_BIT_CTL];
        `AMON_OFS_SINGLE_START:
          single_start <= pwdata_in[`AMON_BIT_CTL];
        `AMON_OFS_INTERVAL: interval_length <= pwdata_in;
        default: begin
        end
      endcase
    end
  end

  // Writing 1 to either start bit launches collection from idle
  assign start_req = wr_acc && pwdata_in[`AMON_BIT_CTL]
                  && ((local_ofs == `AMON_OFS_REPEAT_START)
                  || (local_ofs == `AMON_OFS_SINGLE_START));

  // -------------------------------------------------------------------
  // Interval sequencer
  // -------------------------------------------------------------------
  // A zero length is run as one cycle rather than wrapping 2^32 times
  assign last_cyc = (interval_length == 32'h0000_0000) ? 32'h0000_0000
                  : interval_length - 32'h0000_0001;
  assign interval_end = (state == amon_pkg::ST_RUN) && (cyc == last_cyc);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state <= amon_pkg::ST_IDLE;
      cyc <= 32'h0000_0000;
    end else begin
      case (state)
        amon_pkg::ST_IDLE: begin
          cyc <= 32'h0000_0000;
          if (start_req) begin
            state <= amon_pkg::ST_RUN;
          end
        end
        amon_pkg::ST_RUN: begin
          if (interval_end) begin
            cyc <= 32'h0000_0000;
            // Mode is sampled at the end, so clearing it stops cleanly
            if (!repeat_start_ctl) begin
              state <= amon_pkg::ST_IDLE;
            end
          end else begin
            cyc <= cyc + 32'h0000_0001;
          end
        end
        default: state <= amon_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state == amon_pkg::ST_IDLE) ? start_req
                : !(interval_end && !repeat_start_ctl);
    end
  end

  // Set wins over the read clear so a completion is never lost
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= interval_end
               || (done_out && !(rd_done_acc
               && prdata_out[`AMON_BIT_CTL]));
    end
  end

  // -------------------------------------------------------------------
  // Event decode
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      last_rd <= 2'b00;
    end else begin
      if (cmd_valid_in[0] && is_read(cmd_pc0_in)) last_rd[0] <= 1'b1;
      if (cmd_valid_in[0] && is_write(cmd_pc0_in)) last_rd[0] <= 1'b0;
      if (cmd_valid_in[1] && is_read(cmd_pc1_in)) last_rd[1] <= 1'b1;
      if (cmd_valid_in[1] && is_write(cmd_pc1_in)) last_rd[1] <= 1'b0;
    end
  end

  always_comb begin
    amon_pkg::amon_cmd_e c;
    int b;
    c = amon_pkg::CMD_WRITE;
    b = 0;
    ev = '0;
    for (int p = 0; p < 2; p++) begin
      c = (p == 0) ? cmd_pc0_in : cmd_pc1_in;
      b = p * `AMON_EVT_PER_PC;
      if (cmd_valid_in[p]) begin
        ev[b + int'(amon_pkg::EV_WR)] = c == amon_pkg::CMD_WRITE;
        ev[b + int'(amon_pkg::EV_WRAP)] =
          c == amon_pkg::CMD_WRITE_AP;
        ev[b + int'(amon_pkg::EV_RD)] = c == amon_pkg::CMD_READ;
        ev[b + int'(amon_pkg::EV_RDAP)] =
          c == amon_pkg::CMD_READ_AP;
        ev[b + int'(amon_pkg::EV_REF)] =
          c == amon_pkg::CMD_REFRESH;
        ev[b + int'(amon_pkg::EV_ACT)] =
          c == amon_pkg::CMD_ACTIVATE;
        ev[b + int'(amon_pkg::EV_PRE)] =
          c == amon_pkg::CMD_PRE_BANK;
        ev[b + int'(amon_pkg::EV_PREALL)] =
          c == amon_pkg::CMD_PRE_ALL;
        ev[b + int'(amon_pkg::EV_TURN)] =
          is_write(c) && last_rd[p];
      end
      ev[b + int'(amon_pkg::EV_AGE)] = age_limit_in[p];
      ev[b + int'(amon_pkg::EV_RMW)] = rmw_in[p];
    end
    ev[`AMON_IDX_PD] = powerdown_in;
    ev[`AMON_IDX_SR] = selfrefresh_in;
  end

  // -------------------------------------------------------------------
  // Counters
  // -------------------------------------------------------------------
  // The end cycle's events belong to the closing interval
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < `AMON_NUM_CNT; i++) begin
      if (reset_in || interval_end || (start_req && !busy_out)) begin
        run_cnt[i] <= `AMON_RST_COUNT;
      end else if (state == amon_pkg::ST_RUN) begin
        run_cnt[i] <= run_cnt[i] + {31'h0000_0000, ev[i]};
      end
    end
  end

  // Visible copies move only at an interval end
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < `AMON_NUM_CNT; i++) begin
      if (reset_in) begin
        trk_cnt[i] <= `AMON_RST_COUNT;
      end else if (interval_end) begin
        trk_cnt[i] <= run_cnt[i] + {31'h0000_0000, ev[i]};
      end
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  sequence s_end;
    interval_end;
  endsequence

  sequence s_done_read;
    rd_done_acc && prdata_out[`AMON_BIT_CTL] && !interval_end;
  endsequence

  property p_start_runs;
    @(posedge ref_clk_in) disable iff (reset_in)
    (state == amon_pkg::ST_IDLE && start_req)
      |=> state == amon_pkg::ST_RUN && busy_out && cyc == 32'h0000_0000;
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("start write did not launch an interval");

  property p_done_set;
    @(posedge ref_clk_in) disable iff (reset_in)
    s_end |=> done_out;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done not set at interval end");

  property p_done_clear;
    @(posedge ref_clk_in) disable iff (reset_in)
    s_done_read |=> !done_out;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done not cleared after read of one");

  property p_repeat;
    @(posedge ref_clk_in) disable iff (reset_in)
    s_end ##0 repeat_start_ctl |=> state == amon_pkg::ST_RUN;
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat mode did not restart");

  property p_single;
    @(posedge ref_clk_in) disable iff (reset_in)
    s_end ##0 !repeat_start_ctl |=> state == amon_pkg::ST_IDLE && !busy_out;
  endproperty
  a_single: assert property (p_single)
    else $error("single mode ran past one interval");

  property p_track_hold;
    @(posedge ref_clk_in) disable iff (reset_in)
    !interval_end |=> $stable(trk_cnt[0]) && $stable(trk_cnt[`AMON_IDX_PD]);
  endproperty
  a_track_hold: assert property (p_track_hold)
    else $error("tracking register moved mid interval");

  property p_track_load;
    @(posedge ref_clk_in) disable iff (reset_in)
    s_end |=> trk_cnt[`AMON_IDX_SR] ==
      $past(run_cnt[`AMON_IDX_SR]) + {31'h0000_0000, $past(selfrefresh_in)};
  endproperty
  a_track_load: assert property (p_track_load)
    else $error("self-refresh count not saved at interval end");

  property p_length;
    @(posedge ref_clk_in) disable iff (reset_in)
    (state == amon_pkg::ST_RUN && cyc != last_cyc) |=> !$stable(cyc)
      && cyc == $past(cyc) + 32'h0000_0001;
  endproperty
  a_length: assert property (p_length)
    else $error("interval cycle count did not advance");

  property p_turn;
    @(posedge ref_clk_in) disable iff (reset_in)
    (cmd_valid_in[0] && is_read(cmd_pc0_in)) ##1
      (cmd_valid_in[0] && is_write(cmd_pc0_in))
      |-> ev[int'(amon_pkg::EV_TURN)];
  endproperty
  a_turn: assert property (p_turn)
    else $error("read to write switch not counted");

  property p_region;
    @(posedge ref_clk_in) disable iff (reset_in)
    (setup && !region_hit) |=> pready_out && pslverr_out;
  endproperty
  a_region: assert property (p_region)
    else $error("foreign region not refused");

endmodule

// [sim/amon_ctl_model.sv]
// Behavioural model of the controller's command and power-state outputs
`timescale 1ns/1ps

module amon_ctl_model (
  input wire logic ref_clk_in,
  output logic [1:0] cmd_valid_out,
  output amon_pkg::amon_cmd_e cmd_pc0_out,
  output amon_pkg::amon_cmd_e cmd_pc1_out,
  output logic [1:0] age_limit_out,
  output logic [1:0] rmw_out,
  output logic powerdown_out,
  output logic selfrefresh_out
);
  initial begin
    cmd_valid_out = 2'h0;
    cmd_pc0_out = amon_pkg::CMD_WRITE;
    cmd_pc1_out = amon_pkg::CMD_READ;
    age_limit_out = 2'h0;
    rmw_out = 2'h0;
    powerdown_out = 1'b0;
    selfrefresh_out = 1'b0;
  end

  // ---------------------------------------------------------------
  // One cycle of activity, launched on the falling edge
  // ---------------------------------------------------------------
  // Without a strobe the command lines flip, so a stale code that the
  // monitor wrongly counts would show up as a different command
  task automatic drive(input logic [1:0] v, input amon_pkg::amon_cmd_e c0,
                       input amon_pkg::amon_cmd_e c1, input logic [1:0] a,
                       input logic [1:0] r, input logic pd, input logic sr);
    @(negedge ref_clk_in);
    cmd_valid_out = v;
    cmd_pc0_out = v[0] ? c0 : amon_pkg::amon_cmd_e'(~cmd_pc0_out);
    cmd_pc1_out = v[1] ? c1 : amon_pkg::amon_cmd_e'(~cmd_pc1_out);
    age_limit_out = a;
    rmw_out = r;
    powerdown_out = pd;
    selfrefresh_out = sr;
  endtask

  task automatic idle();
    drive(2'h0, amon_pkg::CMD_WRITE, amon_pkg::CMD_WRITE, 2'h0, 2'h0,
          1'b0, 1'b0);
  endtask
endmodule

// [sim/tb.sv]
// Self-checking testbench of the activity monitor
`timescale 1ns/1ps
`include "amon_regs.svh"

module tb;
  logic ref_clk_in, reset_in, psel, penable, pwrite, pready, pslverr;
  logic busy, done, pd, sr, err;
  logic [21:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] cmd_valid, age, rmw;
  amon_pkg::amon_cmd_e c0, c1;
  int mismatches, comparisons;
  logic [31:0] exp [24];
  logic last_rd [2];
  localparam logic [16:0] OFS0 [11] = '{`AMON_OFS_WR_PC0,
    `AMON_OFS_WRAP_PC0, `AMON_OFS_RD_PC0, `AMON_OFS_RDAP_PC0,
    `AMON_OFS_REF_PC0, `AMON_OFS_ACT_PC0, `AMON_OFS_PRE_PC0,
    `AMON_OFS_PREALL_PC0, `AMON_OFS_TURN_PC0, `AMON_OFS_AGE_PC0,
    `AMON_OFS_RMW_PC0};

  amon_monitor DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .cmd_valid_in(cmd_valid),
    .cmd_pc0_in(c0), .cmd_pc1_in(c1), .age_limit_in(age), .rmw_in(rmw),
    .powerdown_in(pd), .selfrefresh_in(sr), .busy_out(busy),
    .done_out(done));

  amon_ctl_model ctl (.ref_clk_in(ref_clk_in), .cmd_valid_out(cmd_valid),
    .cmd_pc0_out(c0), .cmd_pc1_out(c1), .age_limit_out(age),
    .rmw_out(rmw), .powerdown_out(pd), .selfrefresh_out(sr));

  initial ref_clk_in = 1'b0;
  always #12.5 ref_clk_in = ~ref_clk_in;

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  function automatic logic [16:0] ofs(input int i);
    if (i == 22) return `AMON_OFS_POWERDOWN;
    if (i == 23) return `AMON_OFS_SELFREF;
    return OFS0[i % 11] + ((i >= 11) ? 17'h4 : 17'h0);
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Request held from setup until ready is sampled high
  task automatic apb(input logic wr, input logic [21:0] a,
                     input logic [31:0] wd);
    int n;
    @(negedge ref_clk_in);
    psel = 1'b1;
    penable = 1'b0;
    pwrite = wr;
    paddr = a;
    pwdata = wd;
    @(negedge ref_clk_in);
    penable = 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (n >= 8) check("ready", pready, 32'h1);
    rd = prdata;
    err = pslverr;
    @(negedge ref_clk_in);
    psel = 1'b0;
    penable = 1'b0;
    paddr = ~a;
    pwdata = ~wd;
  endtask

  task automatic reg_wr(input logic [16:0] o, input logic [31:0] d);
    apb(1'b1, {`AMON_REGION_DEFAULT, o}, d);
  endtask

  task automatic reg_rd(input logic [16:0] o);
    apb(1'b0, {`AMON_REGION_DEFAULT, o}, 32'h0);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      reg_rd(`AMON_OFS_DONE);
      n++;
    end while (rd !== 32'h1 && n < 200);
    check("done flag", rd, 32'h1);
    reg_rd(`AMON_OFS_DONE);
    check("done after read", rd, 32'h0);
    check("done pin", {31'h0, done}, 32'h0);
  endtask

  task automatic check_counts();
    for (int i = 0; i < 24; i++) begin
      reg_rd(ofs(i));
      check($sformatf("count %0d", i), rd, exp[i]);
    end
  endtask

  // One cycle of traffic, with the expected totals kept alongside
  task automatic step(input int i);
    logic [1:0] v, a, r;
    logic p, s;
    amon_pkg::amon_cmd_e k [2];
    v = {i % 3 != 0, i % 4 != 3};
    k[0] = amon_pkg::amon_cmd_e'((i * 5 + 2) % 8);
    k[1] = amon_pkg::amon_cmd_e'((i * 5 + 3) % 8);
    a = {i % 5 == 1, i % 4 == 2};
    r = {i % 6 == 0, i % 7 == 4};
    p = i < 7;
    s = i >= 9 && i < 12;
    ctl.drive(v, k[0], k[1], a, r, p, s);
    for (int c = 0; c < 2; c++) begin
      if (v[c]) begin
        exp[c * 11 + int'(k[c])]++;
        if (k[c] inside {amon_pkg::CMD_WRITE, amon_pkg::CMD_WRITE_AP}) begin
          if (last_rd[c]) exp[c * 11 + 8]++;
          last_rd[c] = 1'b0;
        end else if (k[c] inside {amon_pkg::CMD_READ,
                                  amon_pkg::CMD_READ_AP}) begin
          last_rd[c] = 1'b1;
        end
      end
      exp[c * 11 + 9] += 32'(a[c]);
      exp[c * 11 + 10] += 32'(r[c]);
    end
    exp[22] += 32'(p);
    exp[23] += 32'(s);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("busy idle", {31'h0, busy}, 32'h0);
    reg_rd(`AMON_OFS_INTERVAL);
    check("length reset", rd, 32'h0);
    reg_wr(`AMON_OFS_INTERVAL, 32'hA5C3_3C5A);
    reg_rd(`AMON_OFS_INTERVAL);
    check("length 32 bit", rd, 32'hA5C3_3C5A);
    reg_rd(17'h13810);
    check("hole error", {31'h0, err}, 32'h1);
    check("hole data", rd, 32'h0);
    apb(1'b0, {5'h0C, `AMON_OFS_INTERVAL}, 32'h0);
    check("region error", {31'h0, err}, 32'h1);
    reg_wr(`AMON_OFS_WR_PC0, 32'hFFFF_FFFF);
    reg_rd(`AMON_OFS_WR_PC0);
    check("read only count", rd, 32'h0);
  endtask

  task automatic t_single();
    foreach (exp[i]) exp[i] = 32'h0;
    reg_wr(`AMON_OFS_INTERVAL, 32'h28);
    reg_wr(`AMON_OFS_REPEAT_START, 32'h0);
    reg_wr(`AMON_OFS_SINGLE_START, 32'h1);
    check("busy single", {31'h0, busy}, 32'h1);
    for (int i = 0; i < 30; i++) step(i);
    ctl.idle();
    wait_done();
    check_counts();
    repeat (60) @(negedge ref_clk_in);
    check("single stops", {31'h0, busy}, 32'h0);
    check("no second done", {31'h0, done}, 32'h0);
  endtask

  // Interval long enough to read every count before the next update
  task automatic t_repeat();
    foreach (exp[i]) exp[i] = 32'h0;
    reg_wr(`AMON_OFS_INTERVAL, 32'h78);
    reg_wr(`AMON_OFS_REPEAT_START, 32'h1);
    reg_rd(`AMON_OFS_REPEAT_START);
    check("repeat bit", rd, 32'h1);
    for (int i = 0; i < 45; i++) step(i + 7);
    ctl.idle();
    wait_done();
    check("busy repeat", {31'h0, busy}, 32'h1);
    check_counts();
    foreach (exp[i]) exp[i] = 32'h0;
    wait_done();
    check_counts();
    reg_wr(`AMON_OFS_REPEAT_START, 32'h0);
    wait_done();
    repeat (150) @(negedge ref_clk_in);
    check("repeat stops", {31'h0, busy}, 32'h0);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    reset_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 22'h0;
    pwdata = 32'h0;
    mismatches = 0;
    comparisons = 0;
    last_rd = '{1'b0, 1'b0};
    repeat (3) @(negedge ref_clk_in);
    reset_in = 1'b0;
    t_reset();
    t_single();
    t_repeat();
    give_verdict();
  end
endmodule
